// ===== logic/osc_select_ctrl.sv
// Oscillator select control: control register, unlock window, switch sequencer,
// lock and failure status, and a sticky interrupt.
// Assumes a single 125 MHz clock, synchronous inputs, and a register master that
// never issues read and write strobes together.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"

// Notes on behaviour
// [RULE1] Codes 000 and 111 pick divided fast RC
// [RULE2] 001 PLL, 010 primary, 100 secondary, 101 low-power
// [RULE3] New-source field resets from config word
// [RULE4] Lock bit freezes source and PLL selections
// [RULE5] Bit 6 shows USB PLL locked
// [RULE6] Bit 5 shows system PLL locked
// [RULE7] Bit 4 picks sleep or idle on wait
// [RULE8] Bit 3 sticky after monitor sees failure
// [RULE9] Bit 1 enables secondary oscillator
// [RULE10] Bit 0 starts switch, hardware clears when done
// [RULE11] Switch bit resets to two-speed startup setting
// [RULE12] Control writes need a prior unlock
// [RULE13] Two keys back to back open one write
// [RULE14] Locked: ignore source and switch-request writes
module osc_select_ctrl
  import osc_pkg::*;
(
  input  wire logic                   REF_CLK,             // System clock
  input  wire logic                   RSTN,                // Async reset, active low
  input  wire logic                   CLK_EN,              // Freezes all state when low
  input  wire logic [`OSC_ADDR_W-1:0] ADDR,                // Register byte address
  input  wire logic [31:0]            WDATA,               // Write data
  input  wire logic                   WR,                  // Write strobe
  input  wire logic                   RD,                  // Read strobe
  output logic      [31:0]            RDATA,               // Read data, cycle after RD
  input  wire logic [31:0]            DEVICE_CONFIG_WORD_ONE, // Nonvolatile config word
  input  wire logic                   USB_PLL_LOCK_IN,     // USB PLL locked or timer done
  input  wire logic                   SYSTEM_PLL_LOCK_IN,  // System PLL locked or timer done
  input  wire logic                   FAIL_SAFE_CLOCK_MONITOR_FAIL, // Failure pulse or level
  input  wire logic                   SOURCE_READY,        // Target source is running
  output logic      [2:0]             ACTIVE_SOURCE,       // Source now driving the system
  output logic      [2:0]             FAST_RC_POSTSCALE,   // Fast RC divider setting
  output logic                        SECONDARY_OSCILLATOR_ENABLE, // Secondary osc on
  output logic                        SLEEP_ON_WAIT,       // Wait enters sleep when high
  output logic                        SELECTION_LOCK,      // Selections frozen
  output logic                        IRQ                  // Level interrupt
);

  // ********************************************************************
  // Configuration capture
  // ********************************************************************

  logic [2:0]    nsrc_q;          // New-source field
  logic          switch_q;        // Switch request bit
  logic          sosc_en_q;       // Secondary oscillator enable
  logic          sleep_q;         // Sleep on wait
  logic          lock_q;          // Selection lock
  logic          fail_q;          // Clock failure flag
  logic [2:0]    active_q;        // Active source
  logic [2:0]    fast_rc_postscale_q;        // Fast RC postscale
  logic          cfg_loaded_q;    // Config word taken after reset
  osc_sw_state_t sw_state_q;      // Switch sequencer
  logic [7:0]    settle_q;        // Settle counter
  osc_ul_state_t ul_state_q;      // Unlock sequencer
  logic [`OSC_IRQ_W-1:0] ist_q;   // Interrupt status
  logic [`OSC_IRQ_W-1:0] ien_q;   // Interrupt enable
  logic [31:0]   rdata_q;         // Read data register

  // Decoded strobes
  logic wr_ctl;
  logic wr_key;
  logic ctl_open;
  logic sw_done;
  logic [31:0] ctl_view;

  assign wr_ctl   = CLK_EN & WR & (ADDR == `OSC_OFF_CONTROL);
  assign wr_key   = CLK_EN & WR & (ADDR == `OSC_OFF_KEY);
  // Only one control write per unlock goes through
  assign ctl_open = wr_ctl & (ul_state_q == OSC_UL_OPEN);           // see [RULE12]

  localparam logic [7:0] SETTLE_CYC = 8'(`OSC_SWITCH_CYC);

  // ********************************************************************
  // Unlock sequencer
  // ********************************************************************

  // Key one then key two in consecutive cycles; any other bus activity in
  // between, except a repeated key one, drops back, so a stray write cannot half-open the window
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ul_state_q <= OSC_UL_LOCKED;
    end else if (CLK_EN) begin
      unique case (ul_state_q)
        OSC_UL_LOCKED: begin
          if (wr_key && WDATA == `OSC_KEY_ONE) ul_state_q <= OSC_UL_KEY1; // see [RULE13]
        end
        OSC_UL_KEY1: begin
          if (wr_key && WDATA == `OSC_KEY_TWO) begin
            ul_state_q <= OSC_UL_OPEN;                                   // see [RULE13]
          end else if (wr_key && WDATA == `OSC_KEY_ONE) begin
            ul_state_q <= OSC_UL_KEY1;
          end else begin
            ul_state_q <= OSC_UL_LOCKED;
          end
        end
        OSC_UL_OPEN: begin
          // Window closes after the next control write
          if (wr_ctl) ul_state_q <= OSC_UL_LOCKED;                       // see [RULE13]
        end
        default: ul_state_q <= OSC_UL_LOCKED;
      endcase
    end
  end

  // ********************************************************************
  // Control register fields
  // ********************************************************************

  // Reset takes constants; the strap-like config fields are caught on the
  // first enabled edge after release instead
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_loaded_q <= 1'b0;
      nsrc_q       <= 3'h0;
      sosc_en_q    <= 1'b0;
      sleep_q      <= 1'b0;
      lock_q       <= 1'b0;
    end else if (CLK_EN) begin
      if (!cfg_loaded_q) begin
        cfg_loaded_q <= 1'b1;
        nsrc_q       <= DEVICE_CONFIG_WORD_ONE[2:0];                     // see [RULE3]
      end else if (ctl_open) begin
        // Source field frozen while locked
        if (!lock_q) nsrc_q <= WDATA[`OSC_NSRC_HI:`OSC_NSRC_LO];        // see [RULE4] [RULE14]
        sosc_en_q <= WDATA[`OSC_BIT_SOSC_EN];                            // see [RULE9]
        sleep_q   <= WDATA[`OSC_BIT_SLEEP];                              // see [RULE7]
        // Lock is sticky once set, until reset
        lock_q    <= lock_q | WDATA[`OSC_BIT_LOCK];                      // see [RULE4]
      end
    end
  end

  // Fast RC postscale; a selection, so the lock freezes it too
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fast_rc_postscale_q <= `OSC_FRC_DIV_RST;
    end else if (CLK_EN && WR && ADDR == `OSC_OFF_FRC_DIV && !lock_q) begin
      fast_rc_postscale_q <= WDATA[2:0];                                            // see [RULE4]
    end
  end

  // ********************************************************************
  // Switch sequencer
  // ********************************************************************

  // Reserved codes are refused: the request clears without a change
  function automatic logic src_legal(input logic [2:0] s);
    unique case (osc_src_t'(s))
      OSC_SRC_RSV3, OSC_SRC_RSV6: src_legal = 1'b0;                      // see [RULE2]
      default:                    src_legal = 1'b1;                      // see [RULE1] [RULE2]
    endcase
  endfunction

  // Map both fast RC codes to one canonical code for the active source
  function automatic logic [2:0] src_canon(input logic [2:0] s);
    src_canon = (s == OSC_SRC_FRC7) ? OSC_SRC_FRC0 : s;                  // see [RULE1]
  endfunction

  assign sw_done = (sw_state_q == OSC_SW_SETTLE) && (settle_q == 8'h00);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_state_q <= OSC_SW_IDLE;
      settle_q   <= 8'h00;
      active_q   <= 3'h0;
    end else if (CLK_EN) begin
      if (!cfg_loaded_q) begin
        active_q <= src_canon(DEVICE_CONFIG_WORD_ONE[2:0]);             // see [RULE3]
      end else begin
        unique case (sw_state_q)
          OSC_SW_IDLE: begin
            if (switch_q) begin
              if (src_legal(nsrc_q)) sw_state_q <= OSC_SW_WAIT;
            end
          end
          OSC_SW_WAIT: begin
            if (SOURCE_READY) begin
              sw_state_q <= OSC_SW_SETTLE;
              settle_q   <= SETTLE_CYC - 8'h01;
            end
          end
          OSC_SW_SETTLE: begin
            if (settle_q == 8'h00) begin
              active_q   <= src_canon(nsrc_q);                          // see [RULE1] [RULE2]
              sw_state_q <= OSC_SW_IDLE;
            end else begin
              settle_q <= settle_q - 8'h01;
            end
          end
        endcase
      end
    end
  end

  // Switch request: set by an unlocked write, held until the switch ends
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      switch_q <= 1'b0;
    end else if (CLK_EN) begin
      if (!cfg_loaded_q) begin
        switch_q <= DEVICE_CONFIG_WORD_ONE[7];                           // see [RULE11]
      end else if (sw_done || (sw_state_q == OSC_SW_IDLE && switch_q && !src_legal(nsrc_q))) begin
        switch_q <= 1'b0;                                                // see [RULE10]
      end else if (ctl_open && !lock_q && WDATA[`OSC_BIT_SWITCH]) begin
        switch_q <= 1'b1;                                                // see [RULE10] [RULE14]
      end
    end
  end

  // ********************************************************************
  // Failure flag and interrupts
  // ********************************************************************

  // Failure stays until reset; the monitor has no clear path
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fail_q <= 1'b0;
    end else if (CLK_EN && FAIL_SAFE_CLOCK_MONITOR_FAIL) begin
      fail_q <= 1'b1;                                                    // see [RULE8]
    end
  end

  logic [`OSC_IRQ_W-1:0] ev;
  assign ev[`OSC_IRQ_SWITCH_DONE] = sw_done;
  assign ev[`OSC_IRQ_FAIL]        = FAIL_SAFE_CLOCK_MONITOR_FAIL & ~fail_q;

  // Sticky status; an event in the clearing cycle wins
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ist_q <= '0;
    end else if (CLK_EN) begin
      if (WR && ADDR == `OSC_OFF_INT_CLEAR) begin
        ist_q <= (ist_q & ~WDATA[`OSC_IRQ_W-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
    end
  end

  // Enable register
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ien_q <= '0;
    end else if (CLK_EN && WR && ADDR == `OSC_OFF_INT_ENABLE) begin
      ien_q <= WDATA[`OSC_IRQ_W-1:0];
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************

  // Live lock inputs are shown straight; reserved bits read zero
  always_comb begin
    ctl_view                                  = 32'h0000_0000;
    ctl_view[`OSC_NSRC_HI:`OSC_NSRC_LO]       = nsrc_q;
    ctl_view[`OSC_BIT_LOCK]                   = lock_q;
    ctl_view[`OSC_BIT_UPLL_LOCK]              = USB_PLL_LOCK_IN;         // see [RULE5]
    ctl_view[`OSC_BIT_SYSTEM_PLL_LOCK]              = SYSTEM_PLL_LOCK_IN;      // see [RULE6]
    ctl_view[`OSC_BIT_SLEEP]                  = sleep_q;
    ctl_view[`OSC_BIT_FAIL]                   = fail_q;                  // see [RULE8]
    ctl_view[`OSC_BIT_SOSC_EN]                = sosc_en_q;
    ctl_view[`OSC_BIT_SWITCH]                 = switch_q;                // see [RULE10]
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 32'h0000_0000;
    end else if (CLK_EN) begin
      rdata_q <= 32'h0000_0000;
      if (RD) begin
        unique case (ADDR)
          `OSC_OFF_CONTROL:    rdata_q <= ctl_view;
          `OSC_OFF_KEY:        rdata_q <= {30'h0, ul_state_q};
          `OSC_OFF_INT_STATUS: rdata_q <= {30'h0, ist_q};
          `OSC_OFF_INT_ENABLE: rdata_q <= {30'h0, ien_q};
          `OSC_OFF_FRC_DIV:    rdata_q <= {29'h0, fast_rc_postscale_q};
          default:             rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************

  assign RDATA                       = rdata_q;
  assign ACTIVE_SOURCE               = active_q;
  assign FAST_RC_POSTSCALE           = fast_rc_postscale_q;
  assign SECONDARY_OSCILLATOR_ENABLE = sosc_en_q;                        // see [RULE9]
  assign SLEEP_ON_WAIT               = sleep_q;                          // see [RULE7]
  assign SELECTION_LOCK              = lock_q;
  assign IRQ                         = |(ist_q & ien_q);

endmodule : osc_select_ctrl
`default_nettype wire

// ===== logic/osc_consts.svh
// Constants for the oscillator select control block: offsets, fields, resets, counts.
// Assumes a word-wide register port with byte offsets that are multiples of four.
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// Register offsets
`define OSC_ADDR_W           8
`define OSC_OFF_CONTROL      8'h00
`define OSC_OFF_KEY          8'h04
`define OSC_OFF_INT_STATUS   8'h08
`define OSC_OFF_INT_ENABLE   8'h0C
`define OSC_OFF_INT_CLEAR    8'h10
`define OSC_OFF_FRC_DIV      8'h14

// Control register field positions
`define OSC_BIT_SWITCH       0
`define OSC_BIT_SOSC_EN      1
`define OSC_BIT_FAIL         3
`define OSC_BIT_SLEEP        4
`define OSC_BIT_SYSTEM_PLL_LOCK    5
`define OSC_BIT_UPLL_LOCK    6
`define OSC_BIT_LOCK         7
`define OSC_NSRC_LO          8
`define OSC_NSRC_HI          10

// Unlock keys, written back to back
`define OSC_KEY_ONE          32'hAA99_6655
`define OSC_KEY_TWO          32'h5566_99AA

// Interrupt status bit positions
`define OSC_IRQ_SWITCH_DONE  0
`define OSC_IRQ_FAIL         1
`define OSC_IRQ_W            2

// Reset values
`define OSC_FRC_DIV_RST      3'h0

// Switch settle time in ns and the derived cycle count at 125 MHz (8 ns)
`define OSC_CLK_PERIOD_NS    8
`define OSC_SWITCH_NS        200
`define OSC_SWITCH_CYC       ((`OSC_SWITCH_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS)

`endif

// ===== logic/osc_pkg.sv
// Types for the oscillator select control block.
// Assumes the constants header is compiled alongside.
package osc_pkg;

  // Clock source codes as held in the new-source field
  typedef enum logic [2:0] {
    OSC_SRC_FRC0  = 3'h0,
    OSC_SRC_SYSTEM_PLL  = 3'h1,
    OSC_SRC_POSC  = 3'h2,
    OSC_SRC_RSV3  = 3'h3,
    OSC_SRC_SOSC  = 3'h4,
    OSC_SRC_LOW_POWER_INTERNAL_RC  = 3'h5,
    OSC_SRC_RSV6  = 3'h6,
    OSC_SRC_FRC7  = 3'h7
  } osc_src_t;

  // Switch sequencer states
  typedef enum logic [1:0] {
    OSC_SW_IDLE,
    OSC_SW_WAIT,
    OSC_SW_SETTLE
  } osc_sw_state_t;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    OSC_UL_LOCKED,
    OSC_UL_KEY1,
    OSC_UL_OPEN
  } osc_ul_state_t;

endpackage : osc_pkg

// ===== testbench/osc_select_ctrl_sva.sv
// Assertions on the ports of the oscillator select control block.
// Assumes one clock, an active-low async reset and the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_select_ctrl_chk
  import osc_pkg::*;
(
  input wire logic                   REF_CLK,
  input wire logic                   RSTN,
  input wire logic                   CLK_EN,
  input wire logic [`OSC_ADDR_W-1:0] ADDR,
  input wire logic                   WR,
  input wire logic                   RD,
  input wire logic [31:0]            RDATA,
  input wire logic [31:0]            DEVICE_CONFIG_WORD_ONE,
  input wire logic                   USB_PLL_LOCK_IN,
  input wire logic                   SYSTEM_PLL_LOCK_IN,
  input wire logic                   FAIL_SAFE_CLOCK_MONITOR_FAIL,
  input wire logic                   SOURCE_READY,
  input wire logic [2:0]             ACTIVE_SOURCE,
  input wire logic [2:0]             FAST_RC_POSTSCALE,
  input wire logic                   SLEEP_ON_WAIT,
  input wire logic                   SELECTION_LOCK
);
  // ********************
  // Helper state
  // ********************
  logic [1:0] up_q;   // Edges since reset; hides the load from the config word
  logic       fail_q; // A failure was reported since reset
  logic       rd_ctl; // Control register read taken
  assign rd_ctl = CLK_EN && RD && (ADDR == `OSC_OFF_CONTROL);
  // Early-edge counter and failure memory
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      up_q   <= 2'h0;
      fail_q <= 1'h0;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      if (CLK_EN && FAIL_SAFE_CLOCK_MONITOR_FAIL) fail_q <= 1'h1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // ********************
  // Assertions
  // ********************
  AST_SYSTEM_PLL_BIT: assert property (rd_ctl |=> RDATA[5] == $past(SYSTEM_PLL_LOCK_IN))
    else $error("system pll lock bit wrong");
  AST_UPLL_BIT: assert property (rd_ctl |=> RDATA[6] == $past(USB_PLL_LOCK_IN))
    else $error("usb pll lock bit wrong");
  AST_FAIL_STICKY: assert property (rd_ctl && fail_q |=> RDATA[3])
    else $error("clock failure flag lost");
  AST_SRC_LEGAL: assert property (ACTIVE_SOURCE inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5})
    else $error("active source code illegal");
  AST_RESET_SOURCE: assert property ($rose(RSTN) && CLK_EN |=>
    ACTIVE_SOURCE == ((DEVICE_CONFIG_WORD_ONE[2:0] == 3'h7) ? 3'h0 : DEVICE_CONFIG_WORD_ONE[2:0]))
    else $error("reset source not from config word");
  AST_LOCK_HOLD: assert property ($past(SELECTION_LOCK) |-> SELECTION_LOCK)
    else $error("selection lock dropped");
  AST_PSC_FROZEN: assert property ($past(SELECTION_LOCK) |-> $stable(FAST_RC_POSTSCALE))
    else $error("postscale changed while locked");
  AST_SW_READY: assert property (up_q == 2'h3 && $changed(ACTIVE_SOURCE) |->
    $past(SOURCE_READY, 25))
    else $error("source switched without ready source");
  AST_SLEEP_WR: assert property (up_q == 2'h3 && $changed(SLEEP_ON_WAIT) |->
    $past(CLK_EN && WR && (ADDR == `OSC_OFF_CONTROL)))
    else $error("sleep bit changed without a write");
endmodule : osc_select_ctrl_chk
bind osc_select_ctrl osc_select_ctrl_chk i_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN),
  .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .DEVICE_CONFIG_WORD_ONE(DEVICE_CONFIG_WORD_ONE),
  .USB_PLL_LOCK_IN(USB_PLL_LOCK_IN), .SYSTEM_PLL_LOCK_IN(SYSTEM_PLL_LOCK_IN),
  .FAIL_SAFE_CLOCK_MONITOR_FAIL(FAIL_SAFE_CLOCK_MONITOR_FAIL), .SOURCE_READY(SOURCE_READY),
  .ACTIVE_SOURCE(ACTIVE_SOURCE), .FAST_RC_POSTSCALE(FAST_RC_POSTSCALE),
  .SLEEP_ON_WAIT(SLEEP_ON_WAIT), .SELECTION_LOCK(SELECTION_LOCK));
`default_nettype wire

// ===== testbench/osc_src_model.sv
// Model of the clock sources and PLLs behind the oscillator select block.
// Assumes the bench pulses start whenever a new source is to be brought up.
`timescale 1ns/1ps
`default_nettype none
module osc_src_model (
  input  wire logic clk,       // System clock
  input  wire logic rstn,      // Async reset, active low
  input  wire logic start,     // Bring up a new source
  input  wire logic slow,      // Use the long start-up
  input  wire logic pll_en,    // PLLs powered
  output logic      ready,     // Target source running
  output logic      system_pll_lock, // System PLL locked or timer done
  output logic      upll_lock  // USB PLL locked or timer done
);
  // ********************
  // Start-up timers
  // ********************
  logic [5:0] wait_q; // Cycles left before the source runs
  logic       run_q;  // A source has been started
  logic [3:0] pll_q;  // PLL start-up timer
  // Ready drops on a fresh start, so a stale level never ends a switch early
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 6'h00;
      run_q  <= 1'h0;
    end else if (start) begin
      wait_q <= slow ? 6'h28 : 6'h03;
      run_q  <= 1'h1;
    end else if (wait_q != 6'h00) begin
      wait_q <= wait_q - 6'h01;
    end
  end
  assign ready = run_q && (wait_q == 6'h00);
  // PLL timer restarts whenever the PLLs are powered down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn || !pll_en) pll_q <= 4'h0;
    else if (pll_q != 4'hF) pll_q <= pll_q + 4'h1;
  end
  assign system_pll_lock = (pll_q >= 4'h4);
  assign upll_lock = (pll_q >= 4'h8);
endmodule : osc_src_model
`default_nettype wire

// ===== testbench/osc_select_ctrl_tb.sv
// Self-checking bench for the oscillator select control block.
// Assumes the design, checker and source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_select_ctrl_tb
  import osc_pkg::*;
;
  logic        ref_clk, rstn, clk_en, wr, rd, fail, start, slow, pll_en; // Bench drives
  logic [7:0]  addr;
  logic [31:0] wdata, cfg, rdata, v;
  logic        ready, system_pll, upll, sosc, sleep, lock, irq;                // Design and source model answers
  logic [2:0]  act, psc, last;
  int          fails = 0;
  int          cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  osc_select_ctrl i_osc_select_ctrl (.REF_CLK(ref_clk), .RSTN(rstn), .CLK_EN(clk_en),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .DEVICE_CONFIG_WORD_ONE(cfg),
    .USB_PLL_LOCK_IN(upll), .SYSTEM_PLL_LOCK_IN(system_pll), .FAIL_SAFE_CLOCK_MONITOR_FAIL(fail),
    .SOURCE_READY(ready), .ACTIVE_SOURCE(act), .FAST_RC_POSTSCALE(psc),
    .SECONDARY_OSCILLATOR_ENABLE(sosc), .SLEEP_ON_WAIT(sleep), .SELECTION_LOCK(lock), .IRQ(irq));
  osc_src_model i_osc_src_model (.clk(ref_clk), .rstn(rstn), .start(start), .slow(slow),
    .pll_en(pll_en), .ready(ready), .system_pll_lock(system_pll), .upll_lock(upll));
  // ********************
  // Bus and check tasks
  // ********************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge ref_clk);
  endtask : wr_reg
  task automatic idle();
    wr <= 1'h0;
    @(posedge ref_clk);
  endtask : idle
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd   <= 1'h1;
    @(posedge ref_clk);
    rd <= 1'h0;
    @(posedge ref_clk);
    v = rdata;
    if (m != 32'h0) chk("register", v & m, e);
  endtask : rchk
  // Keys back to back, then the one control write they allow
  task automatic unl(input logic [31:0] d);
    wr_reg(`OSC_OFF_KEY, `OSC_KEY_ONE);
    wr_reg(`OSC_OFF_KEY, `OSC_KEY_TWO);
    wr_reg(`OSC_OFF_CONTROL, d);
    idle();
  endtask : unl
  // Restart the source, request a switch, poll until the request bit falls
  // u low: the request bit is already set (from the config word), so no write
  task automatic sw(input logic [2:0] c, input logic s, input logic u);
    slow  <= s;
    start <= 1'h1;
    @(posedge ref_clk);
    start <= 1'h0;
    if (u) unl({21'h0, c, 8'h13});
    for (int k = 0; k < 100; k++) begin
      rchk(`OSC_OFF_CONTROL, 32'h0, 32'h0);
      if (v[0] === 1'h0) break;
    end
    chk("switch bit", v[0], 1'h0);
  endtask : sw
  task automatic rst(input logic [31:0] c);
    rstn <= 1'h0;
    cfg  <= c;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (2) @(posedge ref_clk);
  endtask : rst
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // ********************
  // Test sequence
  // ********************
  initial begin
    {ref_clk, rstn, wr, rd, fail, start, slow, pll_en} = 8'h00;
    clk_en = 1'h1;
    {addr, wdata, cfg} = 72'h0;
    rst(32'h0000_0082);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0701, 32'h0000_0201);
    chk("reset source", act, 3'h2);
    sw(3'h0, 1'h0, 1'h0);
    rst(32'h0000_0007);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0701, 32'h0000_0700);
    chk("reset fast rc", act, 3'h0);
    wr_reg(`OSC_OFF_CONTROL, 32'h0000_0012);
    idle();
    chk("locked write", sleep, 1'h0);
    wr_reg(`OSC_OFF_KEY, `OSC_KEY_ONE);
    idle();
    wr_reg(`OSC_OFF_KEY, `OSC_KEY_TWO);
    wr_reg(`OSC_OFF_CONTROL, 32'h0000_0012);
    idle();
    chk("split keys", sleep, 1'h0);
    unl(32'h0000_0012);
    chk("sleep on wait", sleep, 1'h1);
    chk("secondary enable", sosc, 1'h1);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0012, 32'h0000_0012);
    wr_reg(`OSC_OFF_CONTROL, 32'h0);
    idle();
    chk("window closed", sleep, 1'h1);
    wr_reg(`OSC_OFF_INT_ENABLE, 32'h1);
    idle();
    last = 3'h0;
    for (int i = 0; i < 8; i++) begin
      sw(i[2:0], i[0], 1'h1);
      if (i != 3 && i != 6) last = (i == 7) ? 3'h0 : i[2:0];
      chk("active source", act, last);
      if (i != 3 && i != 6) chk("switch irq", irq, 1'h1);
      wr_reg(`OSC_OFF_INT_CLEAR, 32'h3);
      idle();
      chk("irq cleared", irq, 1'h0);
    end
    wr_reg(`OSC_OFF_INT_ENABLE, 32'h0);
    idle();
    sw(3'h1, 1'h0, 1'h1);
    chk("irq masked", irq, 1'h0);
    rchk(`OSC_OFF_INT_STATUS, 32'h1, 32'h1);
    wr_reg(`OSC_OFF_INT_ENABLE, 32'h1);
    idle();
    chk("irq unmasked", irq, 1'h1);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0068, 32'h0);
    fail <= 1'h1;
    pll_en <= 1'h1;
    @(posedge ref_clk);
    fail <= 1'h0;
    repeat (10) @(posedge ref_clk);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0068, 32'h0000_0068);
    rchk(`OSC_OFF_INT_STATUS, 32'h2, 32'h2);
    wr_reg(`OSC_OFF_FRC_DIV, 32'h5);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    idle();
    chk("postscale", psc, 3'h5);
    rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
    unl(32'h0000_0580);
    chk("lock set", lock, 1'h1);
    unl(32'h0000_0111);
    rchk(`OSC_OFF_CONTROL, 32'h0000_0791, 32'h0000_0590);
    wr_reg(`OSC_OFF_FRC_DIV, 32'h2);
    idle();
    chk("postscale locked", psc, 3'h5);
    chk("source kept", act, 3'h1);
    complete_run();
  end
  // Watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
endmodule : osc_select_ctrl_tb
`default_nettype wire
